// ===== verilog/mmu_pkg.sv
// constants for the virtual address area translator
package mmu_pkg;
  // register offsets, compared on the low 28 address bits
  localparam logic [31:0] TRANSLATION_CONTROL_OFF = 32'h0fffffe0;
  localparam logic [31:0] PAGE_ENTRY_HIGH_OFF     = 32'h0ffffff0;
  localparam logic [31:0] TABLE_BASE_POINTER_OFF  = 32'h0ffffff8;
  localparam logic [31:0] FAULT_ADDRESS_OFF       = 32'h0ffffffc;
  localparam logic [31:0] PAGE_ENTRY_LOW_OFF      = 32'hfffffff4;
  localparam int          REG_DECODE_W            = 28;
  // translation control fields
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_FLUSH_BIT = 2;
  localparam int          CTRL_SV_BIT    = 8;
  localparam int          CTRL_IX_BIT    = 9;
  localparam logic [31:0] CTRL_WR_MASK   = 32'h00000301;
  localparam logic [31:0] CTRL_RESET     = 32'h00000000;
  localparam logic [31:0] REG_RESET      = 32'h00000000;
  // page entry high / low fields
  localparam int          VPN_LSB   = 10;
  localparam int          VPN_W     = 22;
  localparam int          PROCESS_SPACE_TAG_W    = 8;
  localparam int          PPN_LSB   = 10;
  localparam int          PPN_W     = 19;
  localparam int          FLAGS_LSB = 1;
  localparam int          FLAGS_W   = 8;
  localparam int          F_V       = 7;
  localparam int          F_SZ      = 3;
  localparam int          F_C       = 2;
  localparam int          F_SH      = 0;
  // area decode
  localparam logic [2:0]  AREA_CACHED   = 3'h4;
  localparam logic [2:0]  AREA_UNCACHED = 3'h5;
  localparam logic [2:0]  AREA_SECOND   = 3'h6;
  localparam logic [2:0]  AREA_CTRL     = 3'h7;
  localparam logic [7:0]  RAM_TOP_BYTE  = 8'h7f;
  localparam logic [7:0]  XY_TOP_BYTE   = 8'ha5;
  // lookup buffer shape
  localparam int          WAYS  = 4;
  localparam int          SETS  = 32;
  localparam int          IDX_W = 5;
  localparam int          IDX_LSB = 12;
endpackage

// ===== verilog/lookup_way.sv
// one way of the page lookup buffer: storage, write port and compare
`timescale 1ns/100ps
`default_nettype none
module lookup_way (
  // clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          nrst_i,
  // lookup side
  input  wire logic [mmu_pkg::IDX_W-1:0]     rd_index_i,
  input  wire logic [mmu_pkg::VPN_W-1:0]     vpn_i,
  input  wire logic [mmu_pkg::PROCESS_SPACE_TAG_W-1:0]    process_space_tag_i,
  input  wire logic                          process_space_tag_cmp_i,
  output logic                               hit_o,
  output logic [mmu_pkg::PPN_W-1:0]          ppn_o,
  output logic                               sz_o,
  output logic                               c_o,
  // load and purge side
  input  wire logic                          flush_i,
  input  wire logic                          wr_en_i,
  input  wire logic [mmu_pkg::IDX_W-1:0]     wr_index_i,
  input  wire logic [mmu_pkg::VPN_W-1:0]     wr_vpn_i,
  input  wire logic [mmu_pkg::PROCESS_SPACE_TAG_W-1:0]    wr_process_space_tag_i,
  input  wire logic [mmu_pkg::PPN_W-1:0]     wr_ppn_i,
  input  wire logic [mmu_pkg::FLAGS_W-1:0]   wr_flags_i
);
  logic [mmu_pkg::VPN_W-1:0]   vpn_q   [mmu_pkg::SETS];
  logic [mmu_pkg::PROCESS_SPACE_TAG_W-1:0]  process_space_tag_q  [mmu_pkg::SETS];
  logic [mmu_pkg::PPN_W-1:0]   ppn_q   [mmu_pkg::SETS];
  logic [mmu_pkg::FLAGS_W-1:0] flags_q [mmu_pkg::SETS];
  logic [mmu_pkg::SETS-1:0]    valid_q;
  logic [mmu_pkg::SETS-1:0]    valid_d;
  logic [mmu_pkg::FLAGS_W-1:0] fl;
  logic [mmu_pkg::VPN_W-1:0]   ev;

  // compare at the indexed set
  always_comb begin
    fl    = flags_q[rd_index_i];
    ev    = vpn_q[rd_index_i];
    sz_o  = fl[mmu_pkg::F_SZ];
    c_o   = fl[mmu_pkg::F_C];
    ppn_o = ppn_q[rd_index_i];
    hit_o = valid_q[rd_index_i] && (vpn_i[mmu_pkg::VPN_W-1:2] == ev[mmu_pkg::VPN_W-1:2])
            && (sz_o || (vpn_i[1:0] == ev[1:0]))
            && (fl[mmu_pkg::F_SH] || !process_space_tag_cmp_i
                || (process_space_tag_i == process_space_tag_q[rd_index_i]));
  end

  always_comb begin
    valid_d = valid_q;
    if (flush_i) begin
      valid_d = '0;
    end
    if (wr_en_i) begin
      valid_d[wr_index_i] = wr_flags_i[mmu_pkg::F_V];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      valid_q <= '0;
    end else begin
      valid_q <= valid_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      vpn_q[wr_index_i]   <= wr_vpn_i;
      process_space_tag_q[wr_index_i]  <= wr_process_space_tag_i;
      ppn_q[wr_index_i]   <= wr_ppn_i;
      flags_q[wr_index_i] <= wr_flags_i;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/virtual_address_area_translator.sv
// area decode, page translation and control registers of the memory unit
`timescale 1ns/100ps
`default_nettype none
module virtual_address_area_translator (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // core request
  input  wire logic        req_valid_i,
  input  wire logic [31:0] vaddr_i,
  input  wire logic        write_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        privilege_mode_bit_i,
  input  wire logic        dsp_enable_bit_i,
  input  wire logic        load_entry_i,
  // cache control setting
  input  wire logic        ram_enable_i,
  input  wire logic        cache_enable_i,
  input  wire logic        write_back_i,
  // answer towards bus and cache
  output logic             resp_valid_o,
  output logic [31:0]      phys_addr_o,
  output logic [31:0]      cache_addr_o,
  output logic             cacheable_o,
  output logic             write_through_o,
  output logic             onchip_ram_o,
  output logic             ctrl_area_o,
  output logic             addr_error_o,
  output logic             lookup_miss_o,
  output logic [31:0]      rdata_o
);
  // registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] page_entry_high_q, page_entry_high_d;
  logic [31:0] page_entry_low_q, page_entry_low_d;
  logic [31:0] ttb_q, ttb_d;
  logic [31:0] fault_q, fault_d;
  logic [1:0]  victim_q, victim_d;
  // registered answer
  logic        resp_valid_q, resp_valid_d;
  logic [31:0] phys_q, phys_d;
  logic [31:0] caddr_q, caddr_d;
  logic        cacheable_q, cacheable_d;
  logic        wthru_q, wthru_d;
  logic        ram_q, ram_d;
  logic        carea_q, carea_d;
  logic        aerr_q, aerr_d;
  logic        miss_q, miss_d;
  logic [31:0] rdata_q, rdata_d;
  // lookup buffer wiring
  logic [mmu_pkg::IDX_W-1:0] rd_index;
  logic [mmu_pkg::IDX_W-1:0] wr_index;
  logic                      process_space_tag_cmp;
  logic                      flush;
  logic [mmu_pkg::WAYS-1:0]  wr_en;
  logic [mmu_pkg::WAYS-1:0]  way_hit;
  logic [mmu_pkg::PPN_W-1:0] way_ppn [mmu_pkg::WAYS];
  logic [mmu_pkg::WAYS-1:0]  way_sz;
  logic [mmu_pkg::WAYS-1:0]  way_c;
  // decode scratch
  logic                      translate;
  logic                      hit;
  logic [mmu_pkg::PPN_W-1:0] hppn;
  logic                      hsz;
  logic                      hc;
  logic                      reg_sel;
  logic [27:0]               roff;

  // index, optionally hashed with the process tag
  always_comb begin
    rd_index = vaddr_i[mmu_pkg::IDX_LSB +: mmu_pkg::IDX_W];
    if (ctrl_q[mmu_pkg::CTRL_IX_BIT]) begin
      rd_index = rd_index ^ page_entry_high_q[mmu_pkg::IDX_W-1:0];
    end
    wr_index = page_entry_high_q[mmu_pkg::IDX_LSB +: mmu_pkg::IDX_W];
    if (ctrl_q[mmu_pkg::CTRL_IX_BIT]) begin
      wr_index = wr_index ^ page_entry_high_q[mmu_pkg::IDX_W-1:0];
    end
    process_space_tag_cmp = !(ctrl_q[mmu_pkg::CTRL_SV_BIT] && privilege_mode_bit_i);
    flush    = req_valid_i && write_i && reg_sel
               && (roff == mmu_pkg::TRANSLATION_CONTROL_OFF[27:0])
               && wdata_i[mmu_pkg::CTRL_FLUSH_BIT];
    for (int w = 0; w < mmu_pkg::WAYS; w++) begin
      wr_en[w] = load_entry_i && (victim_q == 2'(w));
    end
  end

  generate
    for (genvar g = 0; g < mmu_pkg::WAYS; g++) begin : gen_way
      lookup_way u_way (
        .clock_i    (clock_i),
        .nrst_i     (nrst_i),
        .rd_index_i (rd_index),
        .vpn_i      (vaddr_i[31:mmu_pkg::VPN_LSB]),
        .process_space_tag_i     (page_entry_high_q[mmu_pkg::PROCESS_SPACE_TAG_W-1:0]),
        .process_space_tag_cmp_i (process_space_tag_cmp),
        .hit_o      (way_hit[g]),
        .ppn_o      (way_ppn[g]),
        .sz_o       (way_sz[g]),
        .c_o        (way_c[g]),
        .flush_i    (flush),
        .wr_en_i    (wr_en[g]),
        .wr_index_i (wr_index),
        .wr_vpn_i   (page_entry_high_q[31:mmu_pkg::VPN_LSB]),
        .wr_process_space_tag_i  (page_entry_high_q[mmu_pkg::PROCESS_SPACE_TAG_W-1:0]),
        .wr_ppn_i   (page_entry_low_q[mmu_pkg::PPN_LSB +: mmu_pkg::PPN_W]),
        .wr_flags_i (page_entry_low_q[mmu_pkg::FLAGS_LSB +: mmu_pkg::FLAGS_W])
      );
    end
  endgenerate

  // request decode and register access
  always_comb begin
    ctrl_d       = ctrl_q;
    page_entry_high_d       = page_entry_high_q;
    page_entry_low_d       = page_entry_low_q;
    ttb_d        = ttb_q;
    fault_d      = fault_q;
    victim_d     = load_entry_i ? victim_q + 2'h1 : victim_q;
    resp_valid_d = req_valid_i;
    phys_d       = vaddr_i;
    cacheable_d  = 1'b0;
    wthru_d      = 1'b1;
    ram_d        = 1'b0;
    carea_d      = 1'b0;
    aerr_d       = 1'b0;
    miss_d       = 1'b0;
    rdata_d      = 32'h00000000;
    translate    = 1'b0;
    hit          = 1'b0;
    hppn         = '0;
    hsz          = 1'b0;
    hc           = 1'b0;
    roff         = vaddr_i[mmu_pkg::REG_DECODE_W-1:0];
    reg_sel      = privilege_mode_bit_i && (vaddr_i[31:29] == mmu_pkg::AREA_CTRL);
    for (int w = mmu_pkg::WAYS - 1; w >= 0; w--) begin
      if (way_hit[w]) begin
        hit  = 1'b1;
        hppn = way_ppn[w];
        hsz  = way_sz[w];
        hc   = way_c[w];
      end
    end
    if (req_valid_i) begin
      if (!privilege_mode_bit_i) begin
        if (!vaddr_i[31]) begin
          translate = 1'b1;
        end else if (dsp_enable_bit_i && (vaddr_i[31:24] == mmu_pkg::XY_TOP_BYTE)) begin
          phys_d = {3'h0, vaddr_i[28:0]};
        end else begin
          aerr_d = 1'b1;
        end
      end else begin
        case (vaddr_i[31:29])
          mmu_pkg::AREA_CACHED: begin
            phys_d      = {1'b0, vaddr_i[30:0]};
            cacheable_d = cache_enable_i;
            wthru_d     = 1'b1;
          end
          mmu_pkg::AREA_UNCACHED: begin
            phys_d = {3'h0, vaddr_i[28:0]};
          end
          mmu_pkg::AREA_CTRL: begin
            carea_d = 1'b1;
          end
          mmu_pkg::AREA_SECOND: begin
            translate = 1'b1;
          end
          default: begin
            if (ram_enable_i && (vaddr_i[31:24] == mmu_pkg::RAM_TOP_BYTE)) begin
              ram_d = 1'b1;
            end else begin
              translate = 1'b1;
            end
          end
        endcase
      end
      if (translate) begin
        wthru_d = !write_back_i;
        if (!ctrl_q[mmu_pkg::CTRL_EN_BIT]) begin
          phys_d      = vaddr_i;
          cacheable_d = cache_enable_i;
        end else if (hit) begin
          cacheable_d = cache_enable_i && hc;
          phys_d      = hsz ? {3'h0, hppn[mmu_pkg::PPN_W-1:2], vaddr_i[11:0]}
                            : {3'h0, hppn, vaddr_i[9:0]};
        end else begin
          miss_d = 1'b1;
        end
      end
      if (aerr_d || miss_d) begin
        fault_d = vaddr_i;
        page_entry_high_d  = {vaddr_i[31:mmu_pkg::VPN_LSB], page_entry_high_q[mmu_pkg::VPN_LSB-1:0]};
      end
      if (reg_sel) begin
        case (roff)
          mmu_pkg::TRANSLATION_CONTROL_OFF[27:0]: begin
            rdata_d = ctrl_q;
            if (write_i) begin
              ctrl_d = wdata_i & mmu_pkg::CTRL_WR_MASK;
            end
          end
          mmu_pkg::PAGE_ENTRY_HIGH_OFF[27:0]: begin
            rdata_d = page_entry_high_q;
            if (write_i) begin
              page_entry_high_d = wdata_i;
            end
          end
          mmu_pkg::PAGE_ENTRY_LOW_OFF[27:0]: begin
            rdata_d = page_entry_low_q;
            if (write_i) begin
              page_entry_low_d = wdata_i;
            end
          end
          mmu_pkg::TABLE_BASE_POINTER_OFF[27:0]: begin
            rdata_d = ttb_q;
            if (write_i) begin
              ttb_d = wdata_i;
            end
          end
          mmu_pkg::FAULT_ADDRESS_OFF[27:0]: begin
            rdata_d = fault_q;
            if (write_i) begin
              fault_d = wdata_i;
            end
          end
          default: begin
            rdata_d = 32'h00000000;
          end
        endcase
      end
    end
    caddr_d = {3'h0, phys_d[28:0]};
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ctrl_q       <= mmu_pkg::CTRL_RESET;
      page_entry_high_q       <= mmu_pkg::REG_RESET;
      page_entry_low_q       <= mmu_pkg::REG_RESET;
      ttb_q        <= mmu_pkg::REG_RESET;
      fault_q      <= mmu_pkg::REG_RESET;
      victim_q     <= 2'h0;
      resp_valid_q <= 1'b0;
      phys_q       <= 32'h00000000;
      caddr_q      <= 32'h00000000;
      cacheable_q  <= 1'b0;
      wthru_q      <= 1'b0;
      ram_q        <= 1'b0;
      carea_q      <= 1'b0;
      aerr_q       <= 1'b0;
      miss_q       <= 1'b0;
      rdata_q      <= 32'h00000000;
    end else begin
      ctrl_q       <= ctrl_d;
      page_entry_high_q       <= page_entry_high_d;
      page_entry_low_q       <= page_entry_low_d;
      ttb_q        <= ttb_d;
      fault_q      <= fault_d;
      victim_q     <= victim_d;
      resp_valid_q <= resp_valid_d;
      phys_q       <= phys_d;
      caddr_q      <= caddr_d;
      cacheable_q  <= cacheable_d;
      wthru_q      <= wthru_d;
      ram_q        <= ram_d;
      carea_q      <= carea_d;
      aerr_q       <= aerr_d;
      miss_q       <= miss_d;
      rdata_q      <= rdata_d;
    end
  end

  assign resp_valid_o    = resp_valid_q;
  assign phys_addr_o     = phys_q;
  assign cache_addr_o    = caddr_q;
  assign cacheable_o     = cacheable_q;
  assign write_through_o = wthru_q;
  assign onchip_ram_o    = ram_q;
  assign ctrl_area_o     = carea_q;
  assign addr_error_o    = aerr_q;
  assign lookup_miss_o   = miss_q;
  assign rdata_o         = rdata_q;

  // checks
  sequence s_priv_req(logic [2:0] area);
    req_valid_i && privilege_mode_bit_i && (vaddr_i[31:29] == area);
  endsequence

  sequence s_user_high;
    req_valid_i && !privilege_mode_bit_i && vaddr_i[31]
    && !(dsp_enable_bit_i && (vaddr_i[31:24] == 8'ha5));
  endsequence

  AST_CACHED_AREA: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_priv_req(3'h4) |=> (phys_addr_o == {1'b0, $past(vaddr_i[30:0])}) && write_through_o
                         && (cacheable_o == $past(cache_enable_i)))
    else $error("cached fixed area mapping wrong");
  AST_UNCACHED_AREA: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_priv_req(3'h5) |=> !cacheable_o && (phys_addr_o == {3'h0, $past(vaddr_i[28:0])}))
    else $error("uncached fixed area mapping wrong");
  AST_FIXED_NO_MISS: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (req_valid_i && privilege_mode_bit_i && (vaddr_i[31:30] == 2'h2))
    |=> !lookup_miss_o && !addr_error_o)
    else $error("fixed area raised an exception");
  AST_CTRL_AREA: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_priv_req(3'h7) |=> ctrl_area_o ##1 !ctrl_area_o || $past(req_valid_i))
    else $error("control area not flagged");
  AST_USER_ERROR: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_user_high |=> addr_error_o && (fault_q == $past(vaddr_i)))
    else $error("user high access without address error");
  AST_XY_SPACE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (req_valid_i && !privilege_mode_bit_i && dsp_enable_bit_i && (vaddr_i[31:24] == 8'ha5))
    |=> !addr_error_o && !cacheable_o && (phys_addr_o[31:29] == 3'h0))
    else $error("dsp space access mishandled");
  AST_PASS_THROUGH: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (req_valid_i && !ctrl_q[0] && !vaddr_i[31] && !(privilege_mode_bit_i && ram_enable_i
     && (vaddr_i[31:24] == 8'h7f))) |=> (phys_addr_o == $past(vaddr_i)) && !lookup_miss_o)
    else $error("disabled translation altered address");
  AST_CACHE_TAG: assert property (@(posedge clock_i) disable iff (!nrst_i)
    resp_valid_o |-> (cache_addr_o == {3'h0, phys_addr_o[28:0]}))
    else $error("cache address keeps upper bits");
  AST_RAM_WINDOW: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (req_valid_i && privilege_mode_bit_i && ram_enable_i && (vaddr_i[31:24] == 8'h7f))
    |=> onchip_ram_o && !lookup_miss_o)
    else $error("on-chip ram window not served");
  AST_MISS_RECORD: assert property (@(posedge clock_i) disable iff (!nrst_i)
    lookup_miss_o |-> (fault_q == $past(vaddr_i)) && (page_entry_high_q[31:10] == $past(vaddr_i[31:10])))
    else $error("miss did not record faulting address");
  AST_RESET_CTRL: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> (ctrl_q == 32'h00000000))
    else $error("translation control not cleared by reset");
endmodule
`default_nettype wire

// ===== sim/core_model.sv
// processor core model issuing requests and mode levels
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // clock
  input  wire logic        clock_i,
  // request towards translator
  output logic             req_valid_o,
  output logic [31:0]      vaddr_o,
  output logic             write_o,
  output logic [31:0]      wdata_o,
  output logic             priv_o,
  output logic             dsp_o,
  output logic             load_o,
  output logic             ram_en_o,
  output logic             cache_en_o,
  output logic             wb_o
);
  initial begin
    {req_valid_o, write_o, priv_o, dsp_o, load_o, ram_en_o, cache_en_o, wb_o} = 8'h00;
    vaddr_o = 32'h00000000;
    wdata_o = 32'h00000000;
  end
  task automatic mode(input logic dsp, input logic ram, input logic cen, input logic wb);
    @(negedge clock_i);
    dsp_o = dsp;
    ram_en_o = ram;
    cache_en_o = cen;
    wb_o = wb;
  endtask
  // one request with priv given by the caller, valid for one clock; address and data are then inverted
  task automatic access(input logic priv, input logic [31:0] va, input logic wr,
                        input logic [31:0] wd);
    @(negedge clock_i);
    req_valid_o = 1'h1;
    vaddr_o = va;
    write_o = wr;
    wdata_o = wd;
    priv_o = priv;
    @(negedge clock_i);
    req_valid_o = 1'h0;
    vaddr_o = ~va;
    wdata_o = ~wd;
  endtask
  // entries loaded stay below physical 80000000
  task automatic load();
    @(negedge clock_i);
    load_o = 1'h1;
    @(negedge clock_i);
    load_o = 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== sim/virtual_address_area_translator_tb_top.sv
// testbench for the virtual address area translator
`timescale 1ns/100ps
`default_nettype none
module virtual_address_area_translator_tb_top;
  logic        clock_i;
  logic        nrst_i;
  logic        req, wr, priv, dsp, ld, ram, cen, wb;
  logic [31:0] va, wd;
  logic        resp, cach, wt, oram, ctrl, aerr, miss;
  logic [31:0] phys, caddr, rdata;
  logic [31:0] flags;
  int          miscompares;
  int          n_tests;
  assign flags = {25'h0, resp, cach, wt, oram, ctrl, aerr, miss};
  core_model u_core (.clock_i(clock_i), .req_valid_o(req), .vaddr_o(va), .write_o(wr),
    .wdata_o(wd), .priv_o(priv), .dsp_o(dsp), .load_o(ld), .ram_en_o(ram),
    .cache_en_o(cen), .wb_o(wb));
  virtual_address_area_translator u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .req_valid_i(req), .vaddr_i(va), .write_i(wr), .wdata_i(wd),
    .privilege_mode_bit_i(priv), .dsp_enable_bit_i(dsp), .load_entry_i(ld),
    .ram_enable_i(ram), .cache_enable_i(cen), .write_back_i(wb),
    .resp_valid_o(resp), .phys_addr_o(phys), .cache_addr_o(caddr), .cacheable_o(cach),
    .write_through_o(wt), .onchip_ram_o(oram), .ctrl_area_o(ctrl), .addr_error_o(aerr),
    .lookup_miss_o(miss), .rdata_o(rdata));
  initial begin
    clock_i = 1'h0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one access, then flags under mask and the physical address
  task automatic go(input logic p, input logic [31:0] a, input logic [31:0] m,
                    input logic [31:0] ef, input logic [31:0] ep);
    u_core.access(p, a, 1'h0, 32'h00000000);
    chk(flags & m, ef);
    chk(phys, ep);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    u_core.access(1'h1, a, 1'h0, 32'h00000000);
    chk(flags & 32'h47, 32'h44);
    chk(rdata, exp);
  endtask
  task automatic wrr(input logic [31:0] a, input logic [31:0] d);
    u_core.access(1'h1, a, 1'h1, d);
  endtask
  initial begin
    repeat (4000) @(posedge clock_i);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    miscompares = 0;
    n_tests = 0;
    nrst_i = 1'h0;
    repeat (12) @(negedge clock_i);
    nrst_i = 1'h1;
    rd(32'hffffffe0, 32'h00000000);
    $display("test reset done");
    u_core.mode(1'h0, 1'h0, 1'h1, 1'h0);
    go(1'h1, 32'h80001000, 32'h7f, 32'h70, 32'h00001000);
    chk(caddr, 32'h00001000);
    go(1'h1, 32'ha0001000, 32'h67, 32'h40, 32'h00001000);
    go(1'h1, 32'hc0001000, 32'h47, 32'h40, 32'hc0001000);
    chk(caddr, 32'h00001000);
    go(1'h0, 32'h12345678, 32'h43, 32'h40, 32'h12345678);
    $display("test fixed and untranslated done");
    go(1'h0, 32'h80000000, 32'h42, 32'h42, 32'h80000000);
    u_core.mode(1'h1, 1'h0, 1'h1, 1'h0);
    go(1'h0, 32'ha5000010, 32'h63, 32'h40, 32'h05000010);
    go(1'h0, 32'ha6000000, 32'h42, 32'h42, 32'ha6000000);
    go(1'h0, 32'hfffffff8, 32'h46, 32'h42, 32'hfffffff8);
    $display("test user areas done");
    go(1'h1, 32'he0000000, 32'h47, 32'h44, 32'he0000000);
    wrr(32'hfffffff8, 32'h12345678);
    rd(32'hfffffff8, 32'h12345678);
    wrr(32'hffffffe0, 32'hffffffff);
    rd(32'hffffffe0, 32'h00000301);
    $display("test registers done");
    go(1'h0, 32'h00400abc, 32'h41, 32'h41, 32'h00400abc);
    rd(32'hfffffffc, 32'h00400abc);
    wrr(32'hfffffff0, 32'h00400012);
    wrr(32'hfffffff4, 32'h01234118);
    rd(32'hfffffff0, 32'h00400012);
    u_core.load();
    go(1'h0, 32'h00400abc, 32'h41, 32'h40, 32'h01234abc);
    go(1'h1, 32'h00400abc, 32'h41, 32'h40, 32'h01234abc);
    wrr(32'hfffffff0, 32'h00400032);
    go(1'h1, 32'hc0400abc, 32'h41, 32'h41, 32'hc0400abc);
    go(1'h1, 32'h00400abc, 32'h41, 32'h40, 32'h01234abc);
    go(1'h0, 32'h00400abc, 32'h41, 32'h41, 32'h00400abc);
    $display("test lookup done");
    u_core.mode(1'h0, 1'h1, 1'h1, 1'h1);
    go(1'h1, 32'h7f000010, 32'h49, 32'h48, 32'h7f000010);
    go(1'h1, 32'h00400abc, 32'h51, 32'h40, 32'h01234abc);
    $display("test on-chip ram and write policy done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
